// *** include/pcsbr_pkg.sv ***
// Purpose: Shared constants for the port clock mode and reset delay bank
// Assumes: APB with 32-bit data, pclk at 125 MHz
// Notes: Offsets are byte addresses, one aligned word per register
package pcsbr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] PCSBR_OFS_CLOCK_MODE = 12'h008;
  localparam logic [11:0] PCSBR_OFS_RST_DELAY = 12'h08C;
  localparam logic [11:0] PCSBR_OFS_DELAY_STAT = 12'h090;

  // ----------------------------------------------------------------
  // Field layout and values
  // ----------------------------------------------------------------
  localparam int PCSBR_NUM_PORTS = 16;
  localparam int PCSBR_MODE_W = 2;
  localparam int PCSBR_DELAY_W = 16;
  localparam logic [1:0] PCSBR_MODE_GLOBAL = 2'h0;
  localparam logic [1:0] PCSBR_MODE_LOCAL = 2'h1;
  localparam logic [15:0] PCSBR_DELAY_RESET = 16'h0000;
  localparam logic [31:0] PCSBR_MODE_RESET = 32'h0000_0000;
  localparam logic [2:0] PCSBR_BOOT_ALL_GLOBAL = 3'h0;

  // ----------------------------------------------------------------
  // Timing: one microsecond in pclk cycles
  // ----------------------------------------------------------------
  localparam int PCSBR_CLK_PERIOD_NS = 8;
  localparam int PCSBR_US_NS = 1000;
  localparam int PCSBR_US_CYCLES_INT = PCSBR_US_NS / PCSBR_CLK_PERIOD_NS;
  localparam logic [7:0] PCSBR_US_CYCLES = 8'(PCSBR_US_CYCLES_INT);

  // ----------------------------------------------------------------
  // Delay timer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PCSBR_T_IDLE = 2'b01,
    PCSBR_T_WAIT = 2'b10
  } pcsbr_tstate_t;

endpackage : pcsbr_pkg

// *** logic/pcsbr_us_timer.sv ***
// Purpose: Microsecond delay between a reset trigger and the reset start
// Assumes: trigger is a one-cycle pulse, delay sampled with it
// Notes: Triggers while a delay runs are ignored
`timescale 1ns/1ns
`default_nettype none
module pcsbr_us_timer
  import pcsbr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic trigger,
  input wire logic [15:0] delay_us,
  output logic busy,
  output logic [15:0] remaining,
  output logic fire
);

  pcsbr_tstate_t state_q, state_d;
  logic [15:0] cnt_q, cnt_d;
  logic [7:0] pre_q, pre_d;
  logic fire_q, fire_d;

  // Next state; prescaler divides pclk down to one microsecond
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    pre_d = pre_q;
    fire_d = 1'b0;
    case (state_q)
      PCSBR_T_IDLE:
      begin
        if (trigger && delay_us == 16'h0000)
        begin
          fire_d = 1'b1;
        end
        else if (trigger)
        begin
          state_d = PCSBR_T_WAIT;
          cnt_d = delay_us;
          pre_d = PCSBR_US_CYCLES - 8'h01;
        end
      end
      PCSBR_T_WAIT:
      begin
        if (pre_q != 8'h00)
        begin
          pre_d = pre_q - 8'h01;
        end
        else if (cnt_q == 16'h0001)
        begin
          fire_d = 1'b1;
          cnt_d = 16'h0000;
          state_d = PCSBR_T_IDLE;
        end
        else
        begin
          cnt_d = cnt_q - 16'h0001;
          pre_d = PCSBR_US_CYCLES - 8'h01;
        end
      end
      default:
      begin
        state_d = PCSBR_T_IDLE;
      end
    endcase
    // Soft reset drops a pending delay; nothing sticky lives here
    if (clear)
    begin
      state_d = PCSBR_T_IDLE;
      cnt_d = 16'h0000;
      pre_d = 8'h00;
      fire_d = 1'b0;
    end
  end

  // Registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= PCSBR_T_IDLE;
      cnt_q <= 16'h0000;
      pre_q <= 8'h00;
      fire_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      pre_q <= pre_d;
      fire_q <= fire_d;
    end
  end

  assign busy = (state_q == PCSBR_T_WAIT);
  assign remaining = cnt_q;
  assign fire = fire_q;

endmodule : pcsbr_us_timer
`default_nettype wire

// *** logic/pcsbr_mode_decode.sv ***
// Purpose: Turns the packed mode register into per-port clock selects
// Assumes: Reserved codes never reach the register
// Notes: Outputs are registered, one cycle after the register
`timescale 1ns/1ns
`default_nettype none
module pcsbr_mode_decode
  import pcsbr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [31:0] modes,
  output logic [15:0] port_local_clock
);

  logic [15:0] sel_q, sel_d;

  always_comb
  begin
    sel_d = 16'h0000;
    for (int p = 0; p < PCSBR_NUM_PORTS; p++)
    begin
      sel_d[p] = (modes[p*PCSBR_MODE_W +: PCSBR_MODE_W] == PCSBR_MODE_LOCAL);
    end
  end

  // Registered so a port sees a clean select
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_q <= 16'h0000;
    end
    else
    begin
      sel_q <= sel_d;
    end
  end

  assign port_local_clock = sel_q;

endmodule : pcsbr_mode_decode
`default_nettype wire

// *** logic/pcsbr_regs.sv ***
// Purpose: APB register bank for port clock modes and reset delay
// Assumes: presetn is the fundamental reset; soft_reset is synchronous
// Notes: Zero wait states; read data and error come from flip-flops
//   A mode write that meets the boot load edge is lost; strap wins
//   Status reads are one cycle old, as reads are captured in setup
//
// Register map
//   0x008 port clock modes, sixteen 2-bit fields
//   0x08C bus reset delay in microseconds, low half
//   0x090 delay status: busy in bit 0, remaining in 31:16
//
// Behaviour
// - Sixteen 2-bit port mode fields, packed
// - Zero global, one local, others reserved
// - Mode writes apply any time, no reset
// - Mode fields loaded from boot pins
// - Wait programmed microseconds before bus reset
// - Delay resets zero; zero means no delay
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module pcsbr_regs
  import pcsbr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic soft_reset,
  input wire logic [2:0] boot_clock_select_pins,
  input wire logic sbr_request_done,
  output logic sbr_start,
  output logic sbr_delay_busy,
  output logic [31:0] port_clock_mode_select,
  output logic [15:0] port_local_clock
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Merge write data into a word under the byte strobes
  function automatic logic [31:0] apply_strb(
    input logic [31:0] old_val,
    input logic [31:0] wdata,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        res[b*8 +: 8] = wdata[b*8 +: 8];
      end
    end
    return res;
  endfunction : apply_strb

  // Word compare; byte lanes of the address are ignored
  function automatic logic word_hit(
    input logic [11:0] addr,
    input logic [11:0] ofs
  );
    return (addr[11:2] == ofs[11:2]);
  endfunction : word_hit

  // Boot strap to a full mode word: zero means all global
  // Limitation: pins pick all-global or all-local, never a mix
  function automatic logic [31:0] boot_modes(input logic [2:0] pins);
    logic [31:0] res;
    res = PCSBR_MODE_RESET;
    for (int p = 0; p < PCSBR_NUM_PORTS; p++)
    begin
      if (pins == PCSBR_BOOT_ALL_GLOBAL)
      begin
        res[p*PCSBR_MODE_W +: PCSBR_MODE_W] = PCSBR_MODE_GLOBAL;
      end
      else
      begin
        res[p*PCSBR_MODE_W +: PCSBR_MODE_W] = PCSBR_MODE_LOCAL;
      end
    end
    return res;
  endfunction : boot_modes

  // Keep old field where new code is reserved
  // A reserved code is dropped silently; no bus error is raised
  function automatic logic [31:0] filter_modes(
    input logic [31:0] old_val,
    input logic [31:0] new_val
  );
    logic [31:0] res;
    logic [1:0] fld;
    res = old_val;
    fld = 2'h0;
    for (int p = 0; p < PCSBR_NUM_PORTS; p++)
    begin
      fld = new_val[p*PCSBR_MODE_W +: PCSBR_MODE_W];
      if (fld == PCSBR_MODE_GLOBAL || fld == PCSBR_MODE_LOCAL)
      begin
        res[p*PCSBR_MODE_W +: PCSBR_MODE_W] = fld;
      end
    end
    return res;
  endfunction : filter_modes

  // ----------------------------------------------------------------
  // Bus phase decode
  // ----------------------------------------------------------------
  logic setup_ph;
  logic access_ph;
  logic wr_en;
  logic hit_mode;
  logic hit_delay;
  logic hit_stat;
  logic hit_any;

  // Zero wait states: every access phase completes at once
  // No wait counter is needed since nothing here is slow to read
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign pready = access_ph;
  assign wr_en = access_ph && pwrite;

  // Address decode on the word address
  always_comb
  begin
    hit_mode = 1'b0;
    hit_delay = 1'b0;
    hit_stat = 1'b0;
    if (word_hit(paddr, PCSBR_OFS_CLOCK_MODE))
    begin
      hit_mode = 1'b1;
    end
    else if (word_hit(paddr, PCSBR_OFS_RST_DELAY))
    begin
      hit_delay = 1'b1;
    end
    else if (word_hit(paddr, PCSBR_OFS_DELAY_STAT))
    begin
      hit_stat = 1'b1;
    end
  end
  assign hit_any = hit_mode || hit_delay || hit_stat;

  // ----------------------------------------------------------------
  // Sticky configuration registers
  // ----------------------------------------------------------------
  logic [31:0] mode_q, mode_d;
  logic [15:0] delay_q, delay_d;
  logic strap_pend_q, strap_pend_d;
  logic [31:0] delay_word;
  logic [31:0] delay_merge;

  // Upper half is reserved, so it always reads and merges as zero
  assign delay_word = {16'h0000, delay_q};

  // Strobe merge of the whole word; only its low half is kept
  assign delay_merge = apply_strb(delay_word, pwdata, pstrb);

  // Next values; soft_reset deliberately absent here
  // strap_pend_q is high only up to the first edge after release
  always_comb
  begin
    mode_d = mode_q;
    delay_d = delay_q;
    strap_pend_d = 1'b0;
    if (strap_pend_q)
    begin
      mode_d = boot_modes(boot_clock_select_pins);
    end
    else if (wr_en && hit_mode)
    begin
      mode_d = filter_modes(mode_q, apply_strb(mode_q, pwdata, pstrb));
    end
    // Delay value programmed by software
    // Lowering it is not blocked; that is left to software
    if (wr_en && hit_delay)
    begin
      delay_d = delay_merge[15:0];
    end
  end

  // Only the fundamental reset clears these
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_q <= PCSBR_MODE_RESET;
      delay_q <= PCSBR_DELAY_RESET;
      strap_pend_q <= 1'b1;
    end
    else
    begin
      mode_q <= mode_d;
      delay_q <= delay_d;
      strap_pend_q <= strap_pend_d;
    end
  end

  // ----------------------------------------------------------------
  // Secondary bus reset delay
  // ----------------------------------------------------------------
  logic tmr_busy;
  logic [15:0] tmr_left;
  logic tmr_fire;

  // Soft reset aborts a pending delay but leaves the sticky
  // registers alone, so the next trigger uses the old delay
  // Delay from processed request to reset
  pcsbr_us_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .clear(soft_reset),
    .trigger(sbr_request_done),
    .delay_us(delay_q),
    .busy(tmr_busy),
    .remaining(tmr_left),
    .fire(tmr_fire)
  );

  assign sbr_start = tmr_fire;
  assign sbr_delay_busy = tmr_busy;

  // ----------------------------------------------------------------
  // Per-port clock selects
  // ----------------------------------------------------------------

  // Selects lag the register by one cycle, so a port
  // switches one clock after the write lands
  // Port n decoded from bits 2n+1:2n
  pcsbr_mode_decode u_decode (
    .pclk(pclk),
    .presetn(presetn),
    .modes(mode_q),
    .port_local_clock(port_local_clock)
  );

  assign port_clock_mode_select = mode_q;

  // ----------------------------------------------------------------
  // Read data and error response
  // ----------------------------------------------------------------
  logic [31:0] rdata_q, rdata_d;
  logic err_q, err_d;

  // Captured in the setup phase so prdata is a flop output;
  // status therefore reflects the cycle before the access edge
  // Writes and unmapped words leave zero; 0x90 ignores writes
  always_comb
  begin
    rdata_d = rdata_q;
    err_d = err_q;
    if (setup_ph)
    begin
      rdata_d = 32'h0000_0000;
      err_d = !hit_any;
      if (!pwrite && hit_mode)
      begin
        rdata_d = mode_q;
      end
      else if (!pwrite && hit_delay)
      begin
        rdata_d = delay_word;
      end
      else if (!pwrite && hit_stat)
      begin
        rdata_d = {tmr_left, 15'h0000, tmr_busy};
      end
    end
  end

  // Bus answer registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      err_q <= err_d;
    end
  end

  // Error shows only during the access phase of a bad address
  assign prdata = rdata_q;
  assign pslverr = err_q && access_ph;

endmodule : pcsbr_regs
`default_nettype wire

// *** tb/pcsbr_regs_properties.sv ***
// Purpose: Checker for the clock mode and reset delay bank
// Assumes: Bench writes whole words (all strobes set)
// Notes: Delay field shadowed here from observed bus writes
`timescale 1ns/1ns
`default_nettype none
module pcsbr_chk
  import pcsbr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic soft_reset,
  input wire logic [2:0] boot_clock_select_pins,
  input wire logic sbr_request_done,
  input wire logic sbr_start,
  input wire logic sbr_delay_busy,
  input wire logic [31:0] port_clock_mode_select,
  input wire logic [15:0] port_local_clock
);
  logic wr_acc;
  logic [15:0] dly_q;
  logic [15:0] dly_d;
  logic [15:0] loc_exp;
  assign wr_acc = psel & penable & pwrite & (pstrb == 4'hF);
  // Shadow delay; partial-strobe writes are not tracked
  always_comb
  begin
    dly_d = dly_q;
    if (wr_acc && paddr == PCSBR_OFS_RST_DELAY)
      dly_d = pwdata[15:0];
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dly_q <= 16'h0000;
    else
      dly_q <= dly_d;
  end
  // Local bit per port from its 2-bit field
  always_comb
  begin
    for (int n = 0; n < 16; n++)
      loc_exp[n] = port_clock_mode_select[2*n +: 2] == 2'h1;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_local_decode: assert property (port_local_clock == $past(loc_exp))
    else $error("local clock bits wrong");
  a_no_reserved: assert property ((port_clock_mode_select & 32'hAAAA_AAAA) == 0)
    else $error("reserved mode code held");
  a_mode_write: assert property (wr_acc && paddr == PCSBR_OFS_CLOCK_MODE
    && (pwdata & 32'hAAAA_AAAA) == 0 |=> port_clock_mode_select == $past(pwdata))
    else $error("mode write not applied");
  a_boot_load: assert property ($rose(presetn) |=> port_clock_mode_select ==
    ($past(boot_clock_select_pins) == 3'h0 ? 32'h0 : 32'h5555_5555))
    else $error("boot mode not loaded");
  a_fire_now: assert property (sbr_request_done && !sbr_delay_busy
    && dly_q == 16'h0 && !soft_reset |=> sbr_start)
    else $error("zero delay start late");
  a_fire_later: assert property (sbr_request_done && !sbr_delay_busy
    && dly_q == 16'h1 && !soft_reset |=> sbr_delay_busy ##124 sbr_delay_busy
    ##1 (sbr_start && !sbr_delay_busy))
    else $error("one us delay wrong");
  a_start_cause: assert property ($rose(sbr_start)
    |-> $past(sbr_delay_busy) || $past(sbr_request_done))
    else $error("start without trigger");
  a_delay_read: assert property (psel && penable && !pwrite
    && paddr == PCSBR_OFS_RST_DELAY |-> prdata == {16'h0000, dly_q})
    else $error("delay read wrong");
  a_sticky_soft: assert property (soft_reset && !(psel && penable && pwrite)
    |=> $stable(port_clock_mode_select))
    else $error("mode lost on soft reset");
  c_boot: cover property ($rose(presetn));
  c_mode_wr: cover property (wr_acc && paddr == PCSBR_OFS_CLOCK_MODE);
  c_delay1: cover property (sbr_request_done && dly_q == 16'h1);
endmodule : pcsbr_chk
bind pcsbr_regs pcsbr_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .soft_reset(soft_reset),
  .boot_clock_select_pins(boot_clock_select_pins),
  .sbr_request_done(sbr_request_done), .sbr_start(sbr_start),
  .sbr_delay_busy(sbr_delay_busy),
  .port_clock_mode_select(port_clock_mode_select),
  .port_local_clock(port_local_clock));
`default_nettype wire

// *** tb/testbench.sv ***
// Purpose: Register and delay tests for the clock mode bank
// Assumes: Zero wait APB slave, 8 ns clock
// Notes: One microsecond is 125 cycles here
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import pcsbr_pkg::*;
  localparam int US_CYC = 1000 / 8;
  logic pclk, presetn, psel, penable, pwrite, soft_reset, done;
  logic pready, pslverr, sbr_start, busy, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, mode_o, rd;
  logic [3:0] pstrb;
  logic [2:0] pins;
  logic [15:0] local_o;
  int num_errors = 0;
  int num_checks = 0;
  int n;
  pcsbr_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .soft_reset(soft_reset), .boot_clock_select_pins(pins),
    .sbr_request_done(done), .sbr_start(sbr_start), .sbr_delay_busy(busy),
    .port_clock_mode_select(mode_o), .port_local_clock(local_o));
  // 125 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // --------
  // Tasks
  // --------
  task automatic final_report();
    if (num_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Request held until pready is sampled high at a rising edge
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Trigger pulse, then count cycles to the start pulse
  task automatic fire(int exp);
    @(posedge pclk);
    done <= 1'b1;
    @(posedge pclk);
    done <= 1'b0;
    n = 0;
    do
    begin
      @(negedge pclk);
      n++;
    end
    while (sbr_start !== 1'b1 && n < 3000);
    check("start cycles", exp, n);
  endtask : fire
  task automatic do_reset(logic [2:0] p);
    presetn <= 1'b0;
    pins <= p;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask : do_reset
  // --------
  // Sequence
  // --------
  initial
  begin
    {presetn, psel, penable, pwrite, soft_reset, done} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    pins = 3'h5;
    do_reset(3'h5);
    apb(1'b0, PCSBR_OFS_CLOCK_MODE, 32'h0);
    check("mode boot", 32'h5555_5555, rd);
    check("local boot", 32'h0000_FFFF, {16'h0, local_o});
    apb(1'b0, PCSBR_OFS_RST_DELAY, 32'h0);
    check("delay reset", 32'h0, rd);
    fire(1);
    // Reserved codes on ports 8..15 leave them local
    apb(1'b1, PCSBR_OFS_CLOCK_MODE, 32'hFFFF_0004);
    apb(1'b0, PCSBR_OFS_CLOCK_MODE, 32'h0);
    check("mode reserved", 32'h5555_0004, rd);
    // Walk one local port across all field positions
    for (int p = 0; p < 16; p++)
    begin
      apb(1'b1, PCSBR_OFS_CLOCK_MODE, 32'h1 << (2 * p));
      repeat (2) @(negedge pclk);
      check("local walk", 32'h1 << p, {16'h0, local_o});
    end
    // Delay is only ever raised, as software is asked to do
    apb(1'b1, PCSBR_OFS_RST_DELAY, 32'hFFFF_0001);
    apb(1'b0, PCSBR_OFS_RST_DELAY, 32'h0);
    check("delay upper", 32'h1, rd);
    fire(US_CYC + 1);
    apb(1'b1, PCSBR_OFS_RST_DELAY, 32'h2);
    fire(2 * US_CYC + 1);
    // Soft reset cancels a running delay, leaves both registers
    apb(1'b1, PCSBR_OFS_RST_DELAY, 32'h7);
    apb(1'b1, PCSBR_OFS_CLOCK_MODE, 32'h1111_1111);
    @(posedge pclk);
    done <= 1'b1;
    @(posedge pclk);
    done <= 1'b0;
    apb(1'b0, PCSBR_OFS_DELAY_STAT, 32'h0);
    check("delay status", 32'h0007_0001, rd);
    @(posedge pclk);
    soft_reset <= 1'b1;
    @(posedge pclk);
    soft_reset <= 1'b0;
    @(negedge pclk);
    check("busy cleared", 32'h0, {31'h0, busy});
    apb(1'b0, PCSBR_OFS_CLOCK_MODE, 32'h0);
    check("mode sticky", 32'h1111_1111, rd);
    apb(1'b0, PCSBR_OFS_RST_DELAY, 32'h0);
    check("delay sticky", 32'h7, rd);
    apb(1'b0, 12'h100, 32'h0);
    check("unmapped error", 32'h1, {31'h0, er});
    check("unmapped data", 32'h0, rd);
    do_reset(3'h0);
    apb(1'b0, PCSBR_OFS_CLOCK_MODE, 32'h0);
    check("mode boot zero", 32'h0, rd);
    apb(1'b0, PCSBR_OFS_RST_DELAY, 32'h0);
    check("delay fundamental", 32'h0, rd);
    final_report();
  end
  // Hang guard, well above the roughly 540 cycles needed
  initial
  begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    final_report();
  end
endmodule : testbench
`default_nettype wire
